// file: inc/pefm_pkg.sv
// constants and types shared by the port e / port f pin override logic
// assumes one system clock; pins arrive asynchronous to it
package pefm_pkg;

	// ----------------------------------------------------------------
	// port geometry
	// ----------------------------------------------------------------
	localparam int PORT_W = 8;
	localparam int SYNC_STAGES = 3;
	localparam int RST_STAGES = 2;

	// ----------------------------------------------------------------
	// port e bit positions
	// ----------------------------------------------------------------
	localparam int E_CLK_OUT_BIT = 7;
	localparam int E_USI_DO_BIT = 6;
	localparam int E_USI_DATA_BIT = 5;
	localparam int E_USI_CLK_BIT = 4;
	localparam int E_CMP_NEG_BIT = 3;
	localparam int E_SYNC_CLK_BIT = 2;
	localparam int E_TX_BIT = 1;
	localparam int E_RX_BIT = 0;

	// ----------------------------------------------------------------
	// port f bit positions
	// ----------------------------------------------------------------
	localparam int F_TDI_BIT = 7;
	localparam int F_TDO_BIT = 6;
	localparam int F_TMS_BIT = 5;
	localparam int F_TCK_BIT = 4;
	localparam logic [7:0] F_JTAG_MASK = 8'hf0;

	// ----------------------------------------------------------------
	// reset values and test access port codes
	// ----------------------------------------------------------------
	localparam logic [7:0] SYNC_RESET = 8'h00;
	localparam logic [1:0] IR_CAPTURE_LOW = 2'h1;
	localparam int IR_W_DEFAULT = 4;
	localparam int DR_W_DEFAULT = 8;

	typedef enum logic [3:0] {
		TAP_RESET = 4'h0,
		TAP_IDLE = 4'h1,
		TAP_SEL_DR = 4'h2,
		TAP_CAP_DR = 4'h3,
		TAP_SHIFT_DR = 4'h4,
		TAP_EXIT1_DR = 4'h5,
		TAP_PAUSE_DR = 4'h6,
		TAP_EXIT2_DR = 4'h7,
		TAP_UPD_DR = 4'h8,
		TAP_SEL_IR = 4'h9,
		TAP_CAP_IR = 4'ha,
		TAP_SHIFT_IR = 4'hb,
		TAP_EXIT1_IR = 4'hc,
		TAP_PAUSE_IR = 4'hd,
		TAP_EXIT2_IR = 4'he,
		TAP_UPD_IR = 4'hf
	} pefm_tap_state_t;

endpackage : pefm_pkg

// file: src/pefm_tap.sv
// test access port controller with instruction, bypass and one data chain
// assumes tck edges arrive as one-cycle pulses already filtered by the caller
`timescale 1ns/1ps
module pefm_tap #(
	parameter int IR_W = pefm_pkg::IR_W_DEFAULT,
	parameter int DR_W = pefm_pkg::DR_W_DEFAULT
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// control
	input wire logic i_enable,
	input wire logic i_tck_rise,
	input wire logic i_tck_fall,
	input wire logic i_tms,
	input wire logic i_tdi,
	// results
	output logic o_tdo,
	output logic o_shift,
	output logic [IR_W-1:0] o_ir,
	output logic [DR_W-1:0] o_dr,
	output logic o_dr_update,
	output logic o_test_reset
);
	import pefm_pkg::*;

	generate
		if (IR_W < 2 || DR_W < 1)
		begin : g_check
			$error("pefm_tap: widths too small");
		end
	endgenerate

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		pefm_tap_state_t state;
		logic [IR_W-1:0] ir_sh;
		logic [IR_W-1:0] ir;
		logic [DR_W-1:0] dr_sh;
		logic [DR_W-1:0] dr;
		logic bypass;
		logic tdo;
		logic upd;
	} pefm_tap_reg_t;

	localparam logic [IR_W-1:0] IR_BYPASS = '1;

	pefm_tap_reg_t r_reg;
	pefm_tap_reg_t r_next;

	function automatic pefm_tap_state_t pefm_step(input pefm_tap_state_t s, input logic tms);
		unique case (s)
			TAP_RESET: pefm_step = tms ? TAP_RESET : TAP_IDLE;
			TAP_IDLE: pefm_step = tms ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_DR: pefm_step = tms ? TAP_SEL_IR : TAP_CAP_DR;
			TAP_CAP_DR: pefm_step = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
			TAP_SHIFT_DR: pefm_step = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
			TAP_EXIT1_DR: pefm_step = tms ? TAP_UPD_DR : TAP_PAUSE_DR;
			TAP_PAUSE_DR: pefm_step = tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
			TAP_EXIT2_DR: pefm_step = tms ? TAP_UPD_DR : TAP_SHIFT_DR;
			TAP_UPD_DR: pefm_step = tms ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_IR: pefm_step = tms ? TAP_RESET : TAP_CAP_IR;
			TAP_CAP_IR: pefm_step = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
			TAP_SHIFT_IR: pefm_step = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
			TAP_EXIT1_IR: pefm_step = tms ? TAP_UPD_IR : TAP_PAUSE_IR;
			TAP_PAUSE_IR: pefm_step = tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
			TAP_EXIT2_IR: pefm_step = tms ? TAP_UPD_IR : TAP_SHIFT_IR;
			TAP_UPD_IR: pefm_step = tms ? TAP_SEL_DR : TAP_IDLE;
		endcase
	endfunction : pefm_step

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb
	begin
		logic bypass_sel;
		bypass_sel = 1'b0;
		r_next = r_reg;
		r_next.upd = 1'b0;
		bypass_sel = (r_reg.ir == IR_BYPASS);
		if (!i_enable)
		begin
			r_next.state = TAP_RESET;
			r_next.ir = IR_BYPASS;
		end
		else if (i_tck_rise)
		begin
			r_next.state = pefm_step(r_reg.state, i_tms);
			unique case (r_reg.state)
				TAP_RESET: r_next.ir = IR_BYPASS;
				TAP_CAP_IR: r_next.ir_sh = {{(IR_W-2){1'b0}}, IR_CAPTURE_LOW};
				TAP_SHIFT_IR: r_next.ir_sh = {i_tdi, r_reg.ir_sh[IR_W-1:1]};
				TAP_UPD_IR: r_next.ir = r_reg.ir_sh;
				TAP_CAP_DR:
				begin
					r_next.bypass = 1'b0;
					r_next.dr_sh = r_reg.dr;
				end
				TAP_SHIFT_DR:
				begin
					if (bypass_sel)
						r_next.bypass = i_tdi;
					else if (DR_W == 1)
						r_next.dr_sh = i_tdi;
					else
						r_next.dr_sh = {i_tdi, r_reg.dr_sh[DR_W-1:1]};
				end
				TAP_UPD_DR:
				begin
					if (!bypass_sel)
					begin
						r_next.dr = r_reg.dr_sh;
						r_next.upd = 1'b1;
					end
				end
				default:
				begin
				end
			endcase
		end
		// output changes on the falling edge so the tester samples a settled bit
		if (i_enable && i_tck_fall)
		begin
			if (r_reg.state == TAP_SHIFT_IR)
				r_next.tdo = r_reg.ir_sh[0];
			else if (bypass_sel)
				r_next.tdo = r_reg.bypass;
			else
				r_next.tdo = r_reg.dr_sh[0];
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			r_reg <= '{state: TAP_RESET, ir_sh: '0, ir: '1, dr_sh: '0, dr: '0,
				bypass: 1'b0, tdo: 1'b1, upd: 1'b0};
		end
		else
		begin
			r_reg <= r_next;
		end
	end

	assign o_tdo = r_reg.tdo;
	assign o_shift = (r_reg.state == TAP_SHIFT_IR) || (r_reg.state == TAP_SHIFT_DR);
	assign o_ir = r_reg.ir;
	assign o_dr = r_reg.dr;
	assign o_dr_update = r_reg.upd;
	assign o_test_reset = (r_reg.state == TAP_RESET);

endmodule : pefm_tap

// file: src/pefm_mux.sv
// alternate function override of port e and port f pins
// assumes port registers and peripheral controls come from the system clock domain;
// pins are asynchronous and are filtered here before use
//
// Overview of operation
// - Programmed clock fuse drives divided clock on e7, overriding value and direction.
// - With fuse programmed, divided clock stays on e7 through reset.
// - Sync serial clock on e2 is output when direction bit set, input otherwise.
// - e2 serves as serial clock only in synchronous serial mode.
// - Enabled receiver forces e0 to input regardless of its direction bit.
// - Forced receive input gets pull-up when e0 output value is one and pull-ups are not globally disabled.
// - Each e bit is a pin change source; input stays enabled when source and group set.
// - Usi data out on e6, data in on e5, clock on e4; two-wire shares e5/e4.
// - Port f bits 0..7 connect as analog converter channels 0..7.
// - Jtag enabled keeps pull-ups on tdi, tms, tck, even in reset.
// - Jtag enabled removes port f bits 4..7 from general i/o.
// - Tdo drives only in shift states, pulled high otherwise.
// - Tdi data shifts into the selected instruction or data chain.
// - Tap steps by tms, all test operation synchronous to tck.
`timescale 1ns/1ps
module pefm_mux #(
	parameter int IR_W = pefm_pkg::IR_W_DEFAULT,
	parameter int DR_W = pefm_pkg::DR_W_DEFAULT
) (
	// clock and reset
	input wire logic I_REF_CLK,
	input wire logic I_NRST,
	// port registers
	input wire logic [pefm_pkg::PORT_W-1:0] I_PE_OUTPUT_VALUE,
	input wire logic [pefm_pkg::PORT_W-1:0] I_PE_DIRECTION,
	input wire logic [pefm_pkg::PORT_W-1:0] I_PF_OUTPUT_VALUE,
	input wire logic [pefm_pkg::PORT_W-1:0] I_PF_DIRECTION,
	input wire logic I_GLOBAL_PULLUP_DISABLE,
	input wire logic I_SLEEP_INPUT_DISABLE,
	// clock output
	input wire logic I_CLOCK_OUTPUT_FUSE,
	input wire logic I_DIVIDED_CLOCK_OUT,
	// pin change
	input wire logic [pefm_pkg::PORT_W-1:0] I_PIN_CHANGE_SOURCE,
	input wire logic I_PIN_CHANGE_GROUP_ENABLE,
	// universal serial interface
	input wire logic I_USI_THREE_WIRE,
	input wire logic I_USI_DATA_OUT,
	input wire logic I_TWO_WIRE_MODE_ACTIVE,
	input wire logic I_USI_SDA_LINE,
	input wire logic I_USI_SCL_LINE,
	input wire logic I_USI_START_DETECT_EN,
	// asynchronous / synchronous serial port
	input wire logic I_SERIAL_SYNC_MODE,
	input wire logic I_SERIAL_SYNC_CLOCK_OUT,
	input wire logic I_RECEIVER_ENABLE,
	input wire logic I_TRANSMITTER_ENABLE,
	input wire logic I_TX_DATA,
	// comparator and converter
	input wire logic [1:0] I_AIN_DIGITAL_DISABLE,
	input wire logic [2:0] I_ADC_CHANNEL_SEL,
	input wire logic I_ADC_CONVERTING,
	// test access
	input wire logic I_JTAG_ENABLE,
	// pins
	input wire logic [pefm_pkg::PORT_W-1:0] I_PE_PIN,
	input wire logic [pefm_pkg::PORT_W-1:0] I_PF_PIN,
	// port e pin drive
	output logic [pefm_pkg::PORT_W-1:0] O_PE_OUT,
	output logic [pefm_pkg::PORT_W-1:0] O_PE_OE_N,
	output logic [pefm_pkg::PORT_W-1:0] O_PE_PULLUP,
	output logic [pefm_pkg::PORT_W-1:0] O_PE_DIN_EN,
	// port f pin drive
	output logic [pefm_pkg::PORT_W-1:0] O_PF_OUT,
	output logic [pefm_pkg::PORT_W-1:0] O_PF_OE_N,
	output logic [pefm_pkg::PORT_W-1:0] O_PF_PULLUP,
	output logic [pefm_pkg::PORT_W-1:0] O_PF_DIN_EN,
	// filtered inputs to peripherals
	output logic [pefm_pkg::PORT_W-1:0] O_PE_DIN,
	output logic [pefm_pkg::PORT_W-1:0] O_PF_DIN,
	output logic O_USI_DATA_IN,
	output logic O_USI_CLOCK_IN,
	output logic O_SERIAL_SYNC_CLOCK_IN,
	output logic O_RX_DATA,
	// converter routing
	output logic [pefm_pkg::PORT_W-1:0] O_ADC_CHANNEL_ROUTE,
	output logic O_ADC_SWITCH_HAZARD,
	// test access results
	output logic [IR_W-1:0] O_TAP_IR,
	output logic [DR_W-1:0] O_TAP_DR,
	output logic O_TAP_DR_UPDATE,
	output logic O_TAP_TEST_RESET
);
	import pefm_pkg::*;

	// ----------------------------------------------------------------
	// reset release
	// ----------------------------------------------------------------
	logic [RST_STAGES-1:0] rst_sync_reg;
	logic rst_n;

	always_ff @(posedge I_REF_CLK or negedge I_NRST)
	begin
		if (!I_NRST)
			rst_sync_reg <= '0;
		else
			rst_sync_reg <= {rst_sync_reg[RST_STAGES-2:0], 1'b1};
	end

	assign rst_n = rst_sync_reg[RST_STAGES-1];

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [2*PORT_W-1:0] s1;
		logic [2*PORT_W-1:0] s2;
		logic [2*PORT_W-1:0] s3;
		logic [2*PORT_W-1:0] filt;
		logic [2*PORT_W-1:0] filt_prev;
		logic [PORT_W-1:0] pf_out_prev;
		logic hazard;
	} pefm_mux_reg_t;

	pefm_mux_reg_t r_reg;
	pefm_mux_reg_t r_next;

	logic [PORT_W-1:0] pe_filt;
	logic [PORT_W-1:0] pf_filt;
	logic tck_rise;
	logic tck_fall;
	logic tap_tdo;
	logic tap_shift;

	function automatic logic [PORT_W-1:0] pefm_onehot(input logic [2:0] sel);
		pefm_onehot = 8'h01 << sel;
	endfunction : pefm_onehot

	assign pe_filt = r_reg.filt[PORT_W-1:0];
	assign pf_filt = r_reg.filt[2*PORT_W-1:PORT_W];
	// tck is only a sampled pin; edges are taken from the filtered copy
	assign tck_rise = pf_filt[F_TCK_BIT] & ~r_reg.filt_prev[PORT_W+F_TCK_BIT];
	assign tck_fall = ~pf_filt[F_TCK_BIT] & r_reg.filt_prev[PORT_W+F_TCK_BIT];

	// ----------------------------------------------------------------
	// port e override, combinational so the clock output survives reset
	// ----------------------------------------------------------------
	always_comb
	begin
		logic global_pullup_disable;
		global_pullup_disable = I_GLOBAL_PULLUP_DISABLE;
		O_PE_OUT = I_PE_OUTPUT_VALUE;
		O_PE_OE_N = ~I_PE_DIRECTION;
		O_PE_PULLUP = ~I_PE_DIRECTION & I_PE_OUTPUT_VALUE & {PORT_W{~global_pullup_disable}};
		// sleep gating is lifted per pin by an enabled change source
		O_PE_DIN_EN = {PORT_W{~I_SLEEP_INPUT_DISABLE}} |
			(I_PIN_CHANGE_SOURCE & {PORT_W{I_PIN_CHANGE_GROUP_ENABLE}});
		if (I_CLOCK_OUTPUT_FUSE)
		begin
			O_PE_OUT[E_CLK_OUT_BIT] = I_DIVIDED_CLOCK_OUT;
			O_PE_OE_N[E_CLK_OUT_BIT] = 1'b0;
			O_PE_PULLUP[E_CLK_OUT_BIT] = 1'b0;
		end
		if (I_USI_THREE_WIRE)
			O_PE_OUT[E_USI_DO_BIT] = I_USI_DATA_OUT;
		if (I_TWO_WIRE_MODE_ACTIVE)
		begin
			O_PE_OUT[E_USI_DATA_BIT] = 1'b0;
			O_PE_OUT[E_USI_CLK_BIT] = 1'b0;
			O_PE_OE_N[E_USI_DATA_BIT] = ~(~I_USI_SDA_LINE & I_PE_DIRECTION[E_USI_DATA_BIT]);
			O_PE_OE_N[E_USI_CLK_BIT] = ~(~I_USI_SCL_LINE & I_PE_DIRECTION[E_USI_CLK_BIT]);
			O_PE_PULLUP[E_USI_DATA_BIT] = 1'b0;
			O_PE_PULLUP[E_USI_CLK_BIT] = 1'b0;
		end
		if (I_USI_START_DETECT_EN)
		begin
			O_PE_DIN_EN[E_USI_DATA_BIT] = 1'b1;
			O_PE_DIN_EN[E_USI_CLK_BIT] = 1'b1;
		end
		// comparator pins: digital input only while a change source needs it
		if (I_AIN_DIGITAL_DISABLE[1])
			O_PE_DIN_EN[E_CMP_NEG_BIT] = I_PIN_CHANGE_SOURCE[E_CMP_NEG_BIT] &
				I_PIN_CHANGE_GROUP_ENABLE;
		if (I_AIN_DIGITAL_DISABLE[0])
			O_PE_DIN_EN[E_SYNC_CLK_BIT] = I_PIN_CHANGE_SOURCE[E_SYNC_CLK_BIT] &
				I_PIN_CHANGE_GROUP_ENABLE;
		if (I_SERIAL_SYNC_MODE && I_PE_DIRECTION[E_SYNC_CLK_BIT])
		begin
			O_PE_OUT[E_SYNC_CLK_BIT] = I_SERIAL_SYNC_CLOCK_OUT;
			O_PE_PULLUP[E_SYNC_CLK_BIT] = 1'b0;
		end
		if (I_TRANSMITTER_ENABLE)
		begin
			O_PE_OUT[E_TX_BIT] = I_TX_DATA;
			O_PE_OE_N[E_TX_BIT] = 1'b0;
			O_PE_PULLUP[E_TX_BIT] = 1'b0;
		end
		if (I_RECEIVER_ENABLE)
		begin
			O_PE_OE_N[E_RX_BIT] = 1'b1;
			O_PE_PULLUP[E_RX_BIT] = I_PE_OUTPUT_VALUE[E_RX_BIT] & ~global_pullup_disable;
		end
	end

	// ----------------------------------------------------------------
	// port f override
	// ----------------------------------------------------------------
	always_comb
	begin
		logic pud_f;
		pud_f = I_GLOBAL_PULLUP_DISABLE;
		O_PF_OUT = I_PF_OUTPUT_VALUE;
		O_PF_OE_N = ~I_PF_DIRECTION;
		O_PF_PULLUP = ~I_PF_DIRECTION & I_PF_OUTPUT_VALUE & {PORT_W{~pud_f}};
		O_PF_DIN_EN = {PORT_W{~I_SLEEP_INPUT_DISABLE}};
		if (I_JTAG_ENABLE)
		begin
			// reset-independent path: pull-ups hold even while rst_n is low
			O_PF_PULLUP[F_TDI_BIT] = 1'b1;
			O_PF_PULLUP[F_TMS_BIT] = 1'b1;
			O_PF_PULLUP[F_TCK_BIT] = 1'b1;
			O_PF_PULLUP[F_TDO_BIT] = ~tap_shift;
			O_PF_OE_N = O_PF_OE_N | F_JTAG_MASK;
			O_PF_OE_N[F_TDO_BIT] = ~tap_shift;
			O_PF_OUT = (O_PF_OUT & ~F_JTAG_MASK);
			O_PF_OUT[F_TDO_BIT] = tap_tdo;
			O_PF_DIN_EN = O_PF_DIN_EN & ~F_JTAG_MASK;
		end
	end

	// ----------------------------------------------------------------
	// input filtering and conversion watch
	// ----------------------------------------------------------------
	always_comb
	begin
		r_next = r_reg;
		r_next.s1 = {I_PF_PIN, I_PE_PIN};
		r_next.s2 = r_reg.s1;
		r_next.s3 = r_reg.s2;
		// a change counts once the second and third stages agree
		r_next.filt = (r_reg.s2 & r_reg.s3) | (r_reg.filt & (r_reg.s2 ^ r_reg.s3));
		r_next.filt_prev = r_reg.filt;
		r_next.pf_out_prev = O_PF_OUT;
		// flags a driven port f bit that switched while a conversion ran
		r_next.hazard = I_ADC_CONVERTING & |((O_PF_OUT ^ r_reg.pf_out_prev) & ~O_PF_OE_N);
	end

	always_ff @(posedge I_REF_CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			r_reg <= '{s1: {2{SYNC_RESET}}, s2: {2{SYNC_RESET}}, s3: {2{SYNC_RESET}},
				filt: {2{SYNC_RESET}}, filt_prev: {2{SYNC_RESET}}, pf_out_prev: SYNC_RESET,
				hazard: 1'b0};
		end
		else
		begin
			r_reg <= r_next;
		end
	end

	// ----------------------------------------------------------------
	// peripheral inputs and converter routing
	// ----------------------------------------------------------------
	assign O_PE_DIN = pe_filt & O_PE_DIN_EN;
	assign O_PF_DIN = pf_filt & O_PF_DIN_EN;
	assign O_USI_DATA_IN = pe_filt[E_USI_DATA_BIT];
	assign O_USI_CLOCK_IN = pe_filt[E_USI_CLK_BIT];
	assign O_SERIAL_SYNC_CLOCK_IN = I_SERIAL_SYNC_MODE & ~I_PE_DIRECTION[E_SYNC_CLK_BIT] &
		pe_filt[E_SYNC_CLK_BIT];
	assign O_RX_DATA = I_RECEIVER_ENABLE & pe_filt[E_RX_BIT];
	assign O_ADC_CHANNEL_ROUTE = pefm_onehot(I_ADC_CHANNEL_SEL);
	assign O_ADC_SWITCH_HAZARD = r_reg.hazard;

	// ----------------------------------------------------------------
	// test access port
	// ----------------------------------------------------------------
	pefm_tap #(
		.IR_W(IR_W),
		.DR_W(DR_W)
	) u_tap (
		.clk(I_REF_CLK),
		.rst_n(rst_n),
		.i_enable(I_JTAG_ENABLE),
		.i_tck_rise(tck_rise),
		.i_tck_fall(tck_fall),
		.i_tms(pf_filt[F_TMS_BIT]),
		.i_tdi(pf_filt[F_TDI_BIT]),
		.o_tdo(tap_tdo),
		.o_shift(tap_shift),
		.o_ir(O_TAP_IR),
		.o_dr(O_TAP_DR),
		.o_dr_update(O_TAP_DR_UPDATE),
		.o_test_reset(O_TAP_TEST_RESET)
	);

endmodule : pefm_mux

// file: bench/pefm_mux_assertions.sv
// port-level checks of the port e / port f pin overrides
// assumes binding to pefm_mux
`timescale 1ns/1ps
module pefm_mux_assertions (
	// clock and reset
	input wire logic I_REF_CLK,
	input wire logic I_NRST,
	// controls
	input wire logic [7:0] I_PE_OUTPUT_VALUE,
	input wire logic [7:0] I_PE_DIRECTION,
	input wire logic [7:0] I_PE_PIN,
	input wire logic [7:0] I_PIN_CHANGE_SOURCE,
	input wire logic I_PIN_CHANGE_GROUP_ENABLE,
	input wire logic I_GLOBAL_PULLUP_DISABLE,
	input wire logic I_CLOCK_OUTPUT_FUSE,
	input wire logic I_DIVIDED_CLOCK_OUT,
	input wire logic I_TWO_WIRE_MODE_ACTIVE,
	input wire logic I_USI_SDA_LINE,
	input wire logic I_SERIAL_SYNC_MODE,
	input wire logic I_RECEIVER_ENABLE,
	input wire logic I_TRANSMITTER_ENABLE,
	input wire logic I_TX_DATA,
	input wire logic [2:0] I_ADC_CHANNEL_SEL,
	input wire logic I_JTAG_ENABLE,
	// outputs watched
	input wire logic [7:0] O_PE_OUT,
	input wire logic [7:0] O_PE_OE_N,
	input wire logic [7:0] O_PE_PULLUP,
	input wire logic [7:0] O_PE_DIN_EN,
	input wire logic [7:0] O_PF_OE_N,
	input wire logic [7:0] O_PF_PULLUP,
	input wire logic [7:0] O_PF_DIN_EN,
	input wire logic O_USI_DATA_IN,
	input wire logic O_SERIAL_SYNC_CLOCK_IN,
	input wire logic [7:0] O_ADC_CHANNEL_ROUTE,
	input wire logic O_TAP_TEST_RESET,
	input wire logic O_TAP_DR_UPDATE
);
	default clocking cb @(posedge I_REF_CLK); endclocking
	default disable iff (!I_NRST);

	a_clk_out_drive: assert property (
		I_CLOCK_OUTPUT_FUSE |-> !O_PE_OE_N[7] && O_PE_OUT[7] == I_DIVIDED_CLOCK_OUT)
		else $error("e7 clock");
	a_sync_clk_gate: assert property (
		O_SERIAL_SYNC_CLOCK_IN |-> I_SERIAL_SYNC_MODE && !I_PE_DIRECTION[2])
		else $error("sync clock gate");
	a_rx_forces_input: assert property (
		I_RECEIVER_ENABLE |-> O_PE_OE_N[0]
			&& O_PE_PULLUP[0] == (I_PE_OUTPUT_VALUE[0] && !I_GLOBAL_PULLUP_DISABLE))
		else $error("rx pin");
	a_tx_forces_output: assert property (
		I_TRANSMITTER_ENABLE |-> !O_PE_OE_N[1] && O_PE_OUT[1] == I_TX_DATA && !O_PE_PULLUP[1])
		else $error("tx pin");
	a_pc_keeps_din: assert property (
		I_PIN_CHANGE_GROUP_ENABLE |-> (I_PIN_CHANGE_SOURCE & ~O_PE_DIN_EN) == 8'h00)
		else $error("pin change input");
	a_usi_in_follow: assert property (
		$stable(I_PE_PIN[5]) [*8] |-> O_USI_DATA_IN == I_PE_PIN[5])
		else $error("usi data in");
	a_adc_route: assert property (
		O_ADC_CHANNEL_ROUTE == (8'h01 << I_ADC_CHANNEL_SEL))
		else $error("adc route");
	a_jtag_pins: assert property (
		I_JTAG_ENABLE |-> (O_PF_PULLUP & 8'hb0) == 8'hb0 && (O_PF_OE_N & 8'hb0) == 8'hb0
			&& (O_PF_DIN_EN & 8'hf0) == 8'h00)
		else $error("jtag pins");
	a_tdo_idle_high: assert property (
		I_JTAG_ENABLE && O_TAP_TEST_RESET |-> O_PF_OE_N[6] && O_PF_PULLUP[6])
		else $error("tdo idle");
	a_two_wire_od: assert property (
		I_TWO_WIRE_MODE_ACTIVE |-> !O_PE_OUT[5] && !O_PE_PULLUP[5]
			&& O_PE_OE_N[5] == !(!I_USI_SDA_LINE && I_PE_DIRECTION[5]))
		else $error("two-wire e5");
	a_upd_pulse: assert property (O_TAP_DR_UPDATE |=> !O_TAP_DR_UPDATE)
		else $error("update pulse");

	c_fuse: cover property (I_CLOCK_OUTPUT_FUSE && I_DIVIDED_CLOCK_OUT);
	c_tx: cover property (I_TRANSMITTER_ENABLE && I_RECEIVER_ENABLE);
	c_tdo_drive: cover property (I_JTAG_ENABLE && !O_PF_OE_N[6]);
endmodule : pefm_mux_assertions

bind pefm_mux pefm_mux_assertions i_chk (.*);

// file: bench/pefm_board.sv
// board side of ports e and f: pull-ups, released lines and a jtag tester
// assumes the mux drives a pin while its enable is low
`timescale 1ns/1ps
module pefm_board (
	// clock
	input wire logic clk,
	// mux pin drive
	input wire logic [7:0] e_out,
	input wire logic [7:0] e_oe_n,
	input wire logic [7:0] e_pu,
	input wire logic [7:0] f_out,
	input wire logic [7:0] f_oe_n,
	input wire logic [7:0] f_pu,
	// board drive
	input wire logic [7:0] drv_en,
	input wire logic [7:0] drv_val,
	input wire logic jt_on,
	// resolved pins
	output logic [7:0] e_pin,
	output logic [7:0] f_pin
);
	logic fl = 1'b0;
	logic tck = 1'b0;
	logic tms = 1'b1;
	logic tdi = 1'b0;
	logic [7:0] fd_en;
	logic [7:0] fd_val;
	// released lines flip each cycle so a stale level never passes as driven
	always @(posedge clk) fl <= ~fl;
	assign fd_en = jt_on ? 8'hb0 : 8'h00;
	assign fd_val = {tdi, 1'b0, tms, tck, 4'h0};
	always_comb
	begin
		for (int i = 0; i < 8; i++)
		begin
			e_pin[i] = !e_oe_n[i] ? e_out[i] : drv_en[i] ? drv_val[i] : e_pu[i] | fl;
			f_pin[i] = !f_oe_n[i] ? f_out[i] : fd_en[i] ? fd_val[i] : f_pu[i] | fl;
		end
	end
	// one tck period; each phase outlasts the three-stage pin filter
	task automatic jtag_bit(input logic ms, input logic di, output logic td);
		tms = ms;
		tdi = di;
		tck = 1'b0;
		repeat (6) @(posedge clk);
		#1;
		td = f_pin[6];
		tck = 1'b1;
		repeat (6) @(posedge clk);
		#1;
	endtask : jtag_bit
endmodule : pefm_board

// file: bench/testbench.sv
// self-checking bench for the port e / port f pin override block
// assumes pefm_board models the board and jtag tester
`timescale 1ns/1ps
module testbench;
	logic I_REF_CLK, I_NRST, I_GLOBAL_PULLUP_DISABLE, I_SLEEP_INPUT_DISABLE;
	logic I_CLOCK_OUTPUT_FUSE, I_DIVIDED_CLOCK_OUT, I_PIN_CHANGE_GROUP_ENABLE;
	logic I_USI_THREE_WIRE, I_USI_DATA_OUT, I_TWO_WIRE_MODE_ACTIVE, I_USI_SDA_LINE;
	logic I_USI_SCL_LINE, I_USI_START_DETECT_EN, I_SERIAL_SYNC_MODE, I_SERIAL_SYNC_CLOCK_OUT;
	logic I_RECEIVER_ENABLE, I_TRANSMITTER_ENABLE, I_TX_DATA, I_ADC_CONVERTING, I_JTAG_ENABLE;
	logic [1:0] I_AIN_DIGITAL_DISABLE;
	logic [2:0] I_ADC_CHANNEL_SEL;
	logic [7:0] I_PE_OUTPUT_VALUE, I_PE_DIRECTION, I_PF_OUTPUT_VALUE, I_PF_DIRECTION;
	logic [7:0] I_PIN_CHANGE_SOURCE, I_PE_PIN, I_PF_PIN, drv_en, drv_val, td;
	logic [7:0] O_PE_OUT, O_PE_OE_N, O_PE_PULLUP, O_PE_DIN_EN, O_PF_OUT, O_PF_OE_N, O_PF_PULLUP;
	logic [7:0] O_PF_DIN_EN, O_PE_DIN, O_PF_DIN, O_ADC_CHANNEL_ROUTE, O_TAP_DR;
	logic [3:0] O_TAP_IR;
	logic O_USI_DATA_IN, O_USI_CLOCK_IN, O_SERIAL_SYNC_CLOCK_IN, O_RX_DATA;
	logic O_ADC_SWITCH_HAZARD, O_TAP_DR_UPDATE, O_TAP_TEST_RESET;
	int bad_count = 0;
	int tests_run = 0;

	pefm_mux i_dut (.*);
	pefm_board i_brd (.clk(I_REF_CLK), .e_out(O_PE_OUT), .e_oe_n(O_PE_OE_N), .e_pu(O_PE_PULLUP),
		.f_out(O_PF_OUT), .f_oe_n(O_PF_OE_N), .f_pu(O_PF_PULLUP), .drv_en, .drv_val,
		.jt_on(I_JTAG_ENABLE), .e_pin(I_PE_PIN), .f_pin(I_PF_PIN));

	initial
	begin
		I_REF_CLK = 1'b0;
		forever #10 I_REF_CLK = ~I_REF_CLK;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge I_REF_CLK);
		#1;
	endtask : tick

	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		tests_run++;
		if (got !== exp)
		begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task automatic chk1(input string nm, input logic exp, input logic got);
		chk(nm, {7'h0, exp}, {7'h0, got});
	endtask : chk1

	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : give_verdict

	task automatic idle_inputs;
		{I_GLOBAL_PULLUP_DISABLE, I_SLEEP_INPUT_DISABLE, I_CLOCK_OUTPUT_FUSE, I_DIVIDED_CLOCK_OUT,
			I_PIN_CHANGE_GROUP_ENABLE, I_USI_THREE_WIRE, I_USI_DATA_OUT, I_TWO_WIRE_MODE_ACTIVE,
			I_USI_SDA_LINE, I_USI_SCL_LINE, I_USI_START_DETECT_EN, I_SERIAL_SYNC_MODE,
			I_SERIAL_SYNC_CLOCK_OUT, I_RECEIVER_ENABLE, I_TRANSMITTER_ENABLE, I_TX_DATA,
			I_ADC_CONVERTING, I_JTAG_ENABLE, I_AIN_DIGITAL_DISABLE, I_ADC_CHANNEL_SEL,
			I_PE_OUTPUT_VALUE, I_PE_DIRECTION, I_PF_OUTPUT_VALUE, I_PF_DIRECTION,
			I_PIN_CHANGE_SOURCE, drv_en, drv_val} = '0;
	endtask : idle_inputs

	task automatic jseq(input logic [7:0] ms, input logic [7:0] di, input int n);
		logic b;
		td = 8'h00;
		for (int i = 0; i < n; i++)
		begin
			i_brd.jtag_bit(ms[i], di[i], b);
			td[i] = b;
		end
	endtask : jseq

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_clock_out;
		idle_inputs();
		I_CLOCK_OUTPUT_FUSE = 1'b1;
		I_JTAG_ENABLE = 1'b1;
		I_PE_OUTPUT_VALUE = 8'h80;
		for (int p = 0; p < 4; p++)
		begin
			I_NRST = p < 2;
			I_DIVIDED_CLOCK_OUT = p[0];
			tick(1);
			chk1("e7 drive", 1'b0, O_PE_OE_N[7]);
			chk1("e7 clock", p[0], O_PE_OUT[7]);
			chk("jtag pullups", 8'hb0, O_PF_PULLUP & 8'hb0);
		end
		I_NRST = 1'b1;
		tick(4);
		$display("test clock_out done");
	endtask : t_clock_out

	task automatic t_serial;
		idle_inputs();
		I_SERIAL_SYNC_MODE = 1'b1;
		I_SERIAL_SYNC_CLOCK_OUT = 1'b1;
		I_PE_DIRECTION = 8'h04;
		tick(1);
		chk1("xck out", 1'b1, O_PE_OUT[2]);
		chk1("xck drive", 1'b0, O_PE_OE_N[2]);
		I_PE_DIRECTION = 8'h01;
		I_PE_OUTPUT_VALUE = 8'h01;
		drv_en = 8'h04;
		drv_val = 8'h04;
		I_RECEIVER_ENABLE = 1'b1;
		I_TRANSMITTER_ENABLE = 1'b1;
		tick(8);
		chk1("xck in", 1'b1, O_SERIAL_SYNC_CLOCK_IN);
		chk("rx float", 8'h03, {O_PE_OE_N[0], O_RX_DATA});
		chk1("rx pullup", 1'b1, O_PE_PULLUP[0]);
		chk("tx pin", 8'h00, {O_PE_OE_N[1], O_PE_OUT[1], O_PE_PULLUP[1]});
		I_SERIAL_SYNC_MODE = 1'b0;
		I_GLOBAL_PULLUP_DISABLE = 1'b1;
		I_TX_DATA = 1'b1;
		tick(1);
		chk1("xck gated", 1'b0, O_SERIAL_SYNC_CLOCK_IN);
		chk1("rx no pullup", 1'b0, O_PE_PULLUP[0]);
		chk1("tx data", 1'b1, O_PE_OUT[1]);
		$display("test serial done");
	endtask : t_serial

	task automatic t_usi;
		idle_inputs();
		I_USI_THREE_WIRE = 1'b1;
		I_USI_DATA_OUT = 1'b1;
		I_PE_DIRECTION = 8'h40;
		drv_en = 8'h30;
		drv_val = 8'h20;
		tick(8);
		chk("usi pins", 8'h06, {O_PE_OUT[6], O_USI_DATA_IN, O_USI_CLOCK_IN});
		drv_val = 8'h10;
		tick(8);
		chk("usi pins", 8'h05, {O_PE_OUT[6], O_USI_DATA_IN, O_USI_CLOCK_IN});
		I_USI_THREE_WIRE = 1'b0;
		I_TWO_WIRE_MODE_ACTIVE = 1'b1;
		I_USI_SCL_LINE = 1'b1;
		I_PE_DIRECTION = 8'h30;
		drv_en = 8'h00;
		tick(1);
		chk("two wire oe", 8'h10, O_PE_OE_N & 8'h30);
		chk("two wire out", 8'h00, O_PE_OUT & 8'h30);
		I_PE_DIRECTION = 8'h00;
		tick(1);
		chk("two wire off", 8'h30, O_PE_OE_N & 8'h30);
		$display("test usi done");
	endtask : t_usi

	task automatic t_pin_change;
		idle_inputs();
		I_SLEEP_INPUT_DISABLE = 1'b1;
		I_AIN_DIGITAL_DISABLE = 2'h3;
		I_PIN_CHANGE_SOURCE = 8'h5a;
		I_PIN_CHANGE_GROUP_ENABLE = 1'b1;
		tick(1);
		chk("pc din en", 8'h5a, O_PE_DIN_EN);
		I_PIN_CHANGE_GROUP_ENABLE = 1'b0;
		tick(1);
		chk("pc din off", 8'h00, O_PE_DIN_EN);
		$display("test pin_change done");
	endtask : t_pin_change

	task automatic t_adc;
		idle_inputs();
		for (int s = 0; s < 8; s++)
		begin
			I_ADC_CHANNEL_SEL = s[2:0];
			tick(1);
			chk("adc route", 8'h01 << s, O_ADC_CHANNEL_ROUTE);
		end
		{I_ADC_CONVERTING, I_PF_DIRECTION, I_PF_OUTPUT_VALUE} = {1'b1, 8'h01, 8'h01};
		tick(1);
		chk1("hazard", 1'b1, O_ADC_SWITCH_HAZARD);
		tick(1);
		chk1("hazard end", 1'b0, O_ADC_SWITCH_HAZARD);
		$display("test adc done");
	endtask : t_adc

	task automatic t_jtag;
		idle_inputs();
		I_JTAG_ENABLE = 1'b1;
		tick(2);
		chk("jtag oe", 8'hf0, O_PF_OE_N & 8'hf0);
		chk("jtag din", 8'h00, O_PF_DIN_EN & 8'hf0);
		jseq(8'h00, 8'h00, 1);
		chk1("tap idle", 1'b0, O_TAP_TEST_RESET);
		jseq(8'h03, 8'h00, 4);
		chk1("tdo drive", 1'b0, O_PF_OE_N[6]);
		jseq(8'h08, 8'h05, 4);
		chk("ir out", 8'h01, td);
		jseq(8'h01, 8'h00, 2);
		chk("ir", 8'h05, {4'h0, O_TAP_IR});
		chk1("tdo released", 1'b1, O_PF_OE_N[6]);
		jseq(8'h01, 8'h00, 3);
		jseq(8'h80, 8'ha5, 8);
		chk("dr out", 8'h00, td);
		jseq(8'h01, 8'h00, 2);
		chk("dr", 8'ha5, O_TAP_DR);
		jseq(8'h1f, 8'h00, 5);
		chk1("tap reset", 1'b1, O_TAP_TEST_RESET);
		$display("test jtag done");
	endtask : t_jtag

	initial
	begin
		I_NRST = 1'b0;
		idle_inputs();
		repeat (8) @(posedge I_REF_CLK);
		#1;
		I_NRST = 1'b1;
		tick(4);
		t_clock_out();
		t_serial();
		t_usi();
		t_pin_change();
		t_adc();
		t_jtag();
		give_verdict();
	end

	initial
	begin
		repeat (50000) @(posedge I_REF_CLK);
		bad_count++;
		give_verdict();
	end
endmodule : testbench
